// file: qpcc_top.sv
// Position compare, edge capture and interrupt logic of a quadrature encoder.
// Assumes encoder inputs already synchronous to clk; control bits are plain ports.
// What this block does
// R1: Shadow loads active compare on match or zero.
// R2: Compare value only ever passes through shadow.
// R3: Each compare match fires the sync pulse when sync_pulse_width is nonzero.
// R4: Match during pulse restarts full width.
// R5: Unit timer runs only while enabled.
// R6: Unit timer counts up once per clock.
// R7: At period, clear timer, flag unit timeout.
// R8: Unit timeout latches position counter.
// R9: Capture timer counts prescaled capture clocks.
// R10: Unit position event every 2^prescale pulses.
// R11: Unit position event latches, then clears timer.
// R12: New capture period sets status flag.
// R13: Direction change between events flags error.
// R14: Capture timer past 65535 flags overflow.
// R15: Direction change interrupt when enabled.
// R16: Underflow and overflow interrupts when enabled.
// R17: Compare and unit timeout interrupts when enabled.
// R18: Interrupt flags clear after one clock.
// R19: Capture suspended above speed threshold.
// R20: Counter wraps at max and zero.
// R21: One count pulse per quadrature edge.
// R22: Interrupt is OR of enabled flags.
`timescale 1ns/100ps
`default_nettype none
module qpcc_top (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        qep_a,
    input  wire logic                        qep_b,
    input  wire logic [qpcc_pkg::POS_W-1:0]  maximum_position,
    input  wire logic                        compare_write,
    input  wire logic [qpcc_pkg::POS_W-1:0]  position_compare_value,
    input  wire logic                        compare_load_on_match,
    input  wire logic [qpcc_pkg::PW_W-1:0]   sync_pulse_width,
    input  wire logic                        unit_timer_enable,
    input  wire logic [qpcc_pkg::UTMR_W-1:0] unit_period_value,
    input  wire logic [qpcc_pkg::CCPS_W-1:0] capture_prescale,
    input  wire logic [qpcc_pkg::UNIT_POSITION_PRESCALE_W-1:0] unit_position_prescale,
    input  wire logic [qpcc_pkg::SPD_W-1:0]  speed_threshold,
    input  wire logic [qpcc_pkg::STS_N-1:0]  status_clear,
    input  wire logic [qpcc_pkg::INT_N-1:0]  interrupt_enable_reg,
    output logic                             count_pulse,
    output logic                             direction,
    output logic [qpcc_pkg::POS_W-1:0]       position_count,
    output logic [qpcc_pkg::POS_W-1:0]       compare_active,
    output logic                             compare_sync_output,
    output logic [qpcc_pkg::UTMR_W-1:0]      unit_timer_count,
    output logic [qpcc_pkg::POS_W-1:0]       latched_position,
    output logic [qpcc_pkg::CTMR_W-1:0]      capture_timer,
    output logic [qpcc_pkg::CTMR_W-1:0]      capture_period_reg,
    output logic                             capture_suspended,
    output logic [qpcc_pkg::STS_N-1:0]       decoder_status_reg,
    output logic [qpcc_pkg::INT_N-1:0]       interrupt_flag_reg,
    output logic                             interrupt
);
    typedef struct packed {
        logic                        primed;
        logic                        qa_prev;
        logic                        qb_prev;
        logic                        pulse;
        logic                        dir;
        logic [qpcc_pkg::POS_W-1:0]  pos;
        logic [qpcc_pkg::POS_W-1:0]  cmp_shadow;
        logic [qpcc_pkg::POS_W-1:0]  cmp_active;
        logic [qpcc_pkg::UTMR_W-1:0] utmr;
        logic [qpcc_pkg::POS_W-1:0]  latched;
        logic [qpcc_pkg::SPD_W-1:0]  spd_cnt;
        logic                        high_speed;
        logic [qpcc_pkg::PSC_W-1:0]  psc;
        logic [qpcc_pkg::CTMR_W-1:0] ctmr;
        logic [qpcc_pkg::CTMR_W-1:0] cprd;
        logic [15:0]                 upcnt;
        logic                        dir_chg_pend;
        logic [qpcc_pkg::STS_N-1:0]  sts;
        logic [qpcc_pkg::INT_N-1:0]  flags;
        logic                        irq;
    } qpcc_state_t;

    qpcc_state_t s_reg;
    qpcc_state_t s_next;

    // Decoded events of the current cycle, shared with the assertions
    logic                        edge_pulse;
    logic                        fwd;
    logic                        dir_evt;
    logic                        ovf_evt;
    logic                        unf_evt;
    logic                        match_evt;
    logic                        zero_evt;
    logic                        cmp_load;
    logic                        uto_evt;
    logic                        cap_tick;
    logic                        upos_evt;
    logic                        ctmr_ovf;
    logic [qpcc_pkg::POS_W-1:0]  pos_n;
    logic [qpcc_pkg::PSC_W-1:0]  psc_lim;
    logic [15:0]                 unit_position_prescale_lim;
    logic [qpcc_pkg::STS_N-1:0]  sts_set;
    logic [qpcc_pkg::INT_N-1:0]  flag_set;

    // Quadrature edges: exactly one input toggled gives one count
    always_comb begin
        edge_pulse = s_reg.primed && ((qep_a ^ s_reg.qa_prev) ^ (qep_b ^ s_reg.qb_prev)); // R21
        fwd        = qep_a ^ s_reg.qb_prev; // A leading B counts up
        dir_evt    = edge_pulse && (fwd != s_reg.dir);
    end

    // Position counter with wrap in both directions
    always_comb begin
        ovf_evt = edge_pulse && fwd && (s_reg.pos == maximum_position);
        unf_evt = edge_pulse && !fwd && (s_reg.pos == qpcc_pkg::POS_RST);
        pos_n   = s_reg.pos;
        if (ovf_evt) begin
            pos_n = qpcc_pkg::POS_RST; // R20
        end else if (unf_evt) begin
            pos_n = maximum_position; // R20
        end else if (edge_pulse) begin
            pos_n = fwd ? s_reg.pos + 32'h0000_0001 : s_reg.pos - 32'h0000_0001;
        end
    end

    // Compare is checked against the counter value being entered
    always_comb begin
        match_evt = edge_pulse && (pos_n == s_reg.cmp_active); // R3
        zero_evt  = edge_pulse && (pos_n == qpcc_pkg::POS_RST);
        cmp_load  = compare_load_on_match ? match_evt : zero_evt; // R1
    end

    // Timer tick and unit event conditions
    always_comb begin
        uto_evt  = unit_timer_enable && (s_reg.utmr == unit_period_value); // R7
        psc_lim  = (8'h01 << capture_prescale) - 8'h01;
        cap_tick = !s_reg.high_speed && (s_reg.psc == psc_lim); // R9
        unit_position_prescale_lim = (16'h0001 << unit_position_prescale) - 16'h0001;
        upos_evt = !s_reg.high_speed && edge_pulse && (s_reg.upcnt == unit_position_prescale_lim); // R10
        ctmr_ovf = cap_tick && !upos_evt && (s_reg.ctmr == qpcc_pkg::CTMR_MAX);
    end

    // Sticky status sources and one-cycle interrupt sources
    always_comb begin
        sts_set                       = '0;
        sts_set[qpcc_pkg::STS_CAPNEW] = upos_evt; // R12
        sts_set[qpcc_pkg::STS_DIRECTION_CHANGE_ERROR]   = upos_evt && (s_reg.dir_chg_pend || dir_evt); // R13
        sts_set[qpcc_pkg::STS_CAPTURE_OVERFLOW_ERROR]   = ctmr_ovf; // R14
        flag_set                      = '0;
        flag_set[qpcc_pkg::INT_DIR]   = dir_evt; // R15
        flag_set[qpcc_pkg::INT_UNF]   = unf_evt; // R16
        flag_set[qpcc_pkg::INT_OVF]   = ovf_evt; // R16
        flag_set[qpcc_pkg::INT_CMP]   = match_evt; // R17
        flag_set[qpcc_pkg::INT_UTO]   = uto_evt; // R17
    end

    // Next state of the whole block
    always_comb begin
        s_next         = s_reg;
        s_next.primed  = 1'b1;
        s_next.qa_prev = qep_a;
        s_next.qb_prev = qep_b;
        s_next.pulse   = edge_pulse;
        s_next.pos     = pos_n;
        if (edge_pulse) begin
            s_next.dir = fwd;
        end

        // Software only ever reaches the shadow copy
        if (compare_write) begin
            s_next.cmp_shadow = position_compare_value; // R2
        end
        if (cmp_load) begin
            s_next.cmp_active = s_reg.cmp_shadow; // R1
        end

        // Unit timer; held at zero while disabled so a restart is a full period
        if (!unit_timer_enable) begin
            s_next.utmr = qpcc_pkg::UTMR_RST; // R5
        end else if (uto_evt) begin
            s_next.utmr    = qpcc_pkg::UTMR_RST; // R7
            s_next.latched = s_reg.pos; // R8
        end else begin
            s_next.utmr = s_reg.utmr + 32'h0000_0001; // R6
        end

        // Speed estimate from pulses per unit period, saturating
        if (uto_evt) begin
            s_next.high_speed = (s_reg.spd_cnt > speed_threshold); // R19
            s_next.spd_cnt    = {15'h0000, edge_pulse};
        end else if (edge_pulse && s_reg.spd_cnt != 16'hffff) begin
            s_next.spd_cnt = s_reg.spd_cnt + 16'h0001;
        end

        // Capture path; frozen and cleared while fast, which avoids stale periods
        if (s_reg.high_speed) begin
            s_next.psc          = '0; // R19
            s_next.ctmr         = qpcc_pkg::CTMR_RST;
            s_next.upcnt        = 16'h0000;
            s_next.dir_chg_pend = 1'b0;
        end else begin
            s_next.psc = cap_tick ? 8'h00 : s_reg.psc + 8'h01;
            if (cap_tick && s_reg.ctmr != qpcc_pkg::CTMR_MAX) begin
                s_next.ctmr = s_reg.ctmr + 16'h0001; // R9
            end
            if (edge_pulse) begin
                s_next.upcnt = (s_reg.upcnt == unit_position_prescale_lim) ? 16'h0000 : s_reg.upcnt + 16'h0001;
            end
            if (upos_evt) begin
                s_next.cprd         = s_reg.ctmr; // R11
                s_next.ctmr         = qpcc_pkg::CTMR_RST; // R11
                s_next.dir_chg_pend = 1'b0;
            end else if (dir_evt) begin
                s_next.dir_chg_pend = 1'b1;
            end
        end

        // Set wins over a clear arriving in the same cycle
        s_next.sts   = (s_reg.sts & ~status_clear) | sts_set;
        // Flags hold only the events of this cycle, so they clear themselves
        s_next.flags = flag_set; // R18
        s_next.irq   = |(flag_set & interrupt_enable_reg); // R22
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg            <= '0;
            s_reg.pos        <= qpcc_pkg::POS_RST;
            s_reg.cmp_shadow <= qpcc_pkg::CMP_RST;
            s_reg.cmp_active <= qpcc_pkg::CMP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Sync pulse restarts on each registered match
    qpcc_stretch u_stretch (
        .clk     (clk),
        .rst     (rst),
        .trigger (s_reg.flags[qpcc_pkg::INT_CMP]),
        .width   (sync_pulse_width),
        .pulse   (compare_sync_output)
    );

    // Outputs straight from the state
    assign count_pulse        = s_reg.pulse;
    assign direction          = s_reg.dir;
    assign position_count     = s_reg.pos;
    assign compare_active     = s_reg.cmp_active;
    assign unit_timer_count   = s_reg.utmr;
    assign latched_position   = s_reg.latched;
    assign capture_timer      = s_reg.ctmr;
    assign capture_period_reg = s_reg.cprd;
    assign capture_suspended  = s_reg.high_speed;
    assign decoder_status_reg = s_reg.sts;
    assign interrupt_flag_reg = s_reg.flags;
    assign interrupt          = s_reg.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_unit_wrap;
        unit_timer_enable && s_reg.utmr == unit_period_value;
    endsequence

    sequence s_unit_done;
        s_reg.utmr == 32'h0000_0000 && interrupt_flag_reg[qpcc_pkg::INT_UTO];
    endsequence

    sequence s_upos;
        upos_evt;
    endsequence

    sequence s_captured;
        s_reg.ctmr == 16'h0000 && decoder_status_reg[qpcc_pkg::STS_CAPNEW];
    endsequence

    a_shadow_load: assert property ( // R1
        cmp_load |=> compare_active == $past(s_reg.cmp_shadow))
        else $error("active compare not loaded from shadow");

    a_shadow_only: assert property ( // R2
        compare_active != $past(compare_active) |-> $past(cmp_load))
        else $error("active compare changed without a load event");

    a_sync_match: assert property ( // R3
        match_evt && sync_pulse_width != 16'h0000 |-> ##2 compare_sync_output)
        else $error("compare match gave no sync pulse");

    a_unit_idle: assert property ( // R5
        !unit_timer_enable |=> unit_timer_count == 32'h0000_0000
            && !interrupt_flag_reg[qpcc_pkg::INT_UTO])
        else $error("unit timer ran while disabled");

    a_unit_count: assert property ( // R6
        unit_timer_enable && !uto_evt |=> unit_timer_count == $past(unit_timer_count) + 32'h1)
        else $error("unit timer did not step by one");

    a_unit_timeout: assert property ( // R7
        s_unit_wrap |=> s_unit_done)
        else $error("unit timeout did not clear timer and flag");

    a_pos_latch: assert property ( // R8
        s_unit_wrap |=> latched_position == $past(position_count))
        else $error("position not latched on unit timeout");

    a_cap_latch: assert property ( // R11
        s_upos |=> s_captured ##0 capture_period_reg == $past(s_reg.ctmr))
        else $error("capture period not latched");

    a_cap_ovf: assert property ( // R14
        ctmr_ovf |=> decoder_status_reg[qpcc_pkg::STS_CAPTURE_OVERFLOW_ERROR])
        else $error("capture overflow not flagged");

    a_wrap_up: assert property ( // R20
        ovf_evt |=> position_count == 32'h0000_0000 && interrupt_flag_reg[qpcc_pkg::INT_OVF])
        else $error("counter did not wrap to zero");

    a_wrap_down: assert property ( // R20
        unf_evt |=> position_count == $past(maximum_position)
            && interrupt_flag_reg[qpcc_pkg::INT_UNF])
        else $error("counter did not wrap to maximum");

    a_dir_flag: assert property ( // R15
        dir_evt |=> interrupt_flag_reg[qpcc_pkg::INT_DIR] && direction == $past(fwd))
        else $error("direction change not flagged");

    a_direction_change_error_set: assert property ( // R13
        upos_evt && dir_evt |=> decoder_status_reg[qpcc_pkg::STS_DIRECTION_CHANGE_ERROR])
        else $error("direction change error not flagged");

    a_cap_tick: assert property ( // R9
        cap_tick && !upos_evt && capture_timer != 16'hffff
            |=> capture_timer == $past(capture_timer) + 16'h0001)
        else $error("capture timer missed a capture clock");

    a_slow_freeze: assert property ( // R19
        capture_suspended |=> capture_timer == 16'h0000 && $stable(capture_period_reg))
        else $error("capture ran while suspended");

    a_flag_clear: assert property ( // R18
        interrupt_flag_reg[qpcc_pkg::INT_UTO] && !uto_evt
            |=> !interrupt_flag_reg[qpcc_pkg::INT_UTO])
        else $error("unit timeout flag stuck");

    a_irq_or: assert property ( // R22
        ##1 interrupt == |(interrupt_flag_reg & $past(interrupt_enable_reg)))
        else $error("interrupt is not OR of enabled flags");

endmodule : qpcc_top
`default_nettype wire

// file: qpcc_pkg.sv
// Constants shared by the position compare, capture and interrupt logic.
// Assumes a single 250 MHz system clock and a synchronous reset.
package qpcc_pkg;

    // Data path widths
    localparam int POS_W  = 32;
    localparam int UTMR_W = 32;
    localparam int CTMR_W = 16;
    localparam int PSC_W  = 8;
    localparam int UNIT_POSITION_PRESCALE_W = 4;
    localparam int CCPS_W = 3;
    localparam int PW_W   = 16;
    localparam int SPD_W  = 16;

    // Capture timer top count; one more tick is an overflow
    localparam logic [CTMR_W-1:0] CTMR_MAX = 16'hffff;

    // Interrupt flag positions
    localparam int INT_DIR = 0;
    localparam int INT_UNF = 1;
    localparam int INT_OVF = 2;
    localparam int INT_CMP = 3;
    localparam int INT_UTO = 4;
    localparam int INT_N   = 5;

    // Decoder status positions
    localparam int STS_CAPNEW = 0;
    localparam int STS_DIRECTION_CHANGE_ERROR   = 1;
    localparam int STS_CAPTURE_OVERFLOW_ERROR   = 2;
    localparam int STS_N      = 3;

    // Values after reset
    localparam logic [POS_W-1:0]  POS_RST  = 32'h0000_0000;
    localparam logic [POS_W-1:0]  CMP_RST  = 32'h0000_0000;
    localparam logic [UTMR_W-1:0] UTMR_RST = 32'h0000_0000;
    localparam logic [CTMR_W-1:0] CTMR_RST = 16'h0000;
    localparam logic [PW_W-1:0]   PW_RST   = 16'h0000;

endpackage : qpcc_pkg

// file: qpcc_stretch.sv
// Pulse stretcher for the compare sync output.
// Assumes trigger is a one-cycle pulse in the clk domain.
`timescale 1ns/100ps
`default_nettype none
module qpcc_stretch (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     trigger,
    input  wire logic [qpcc_pkg::PW_W-1:0] width,
    output logic                          pulse
);
    typedef struct packed {
        logic [qpcc_pkg::PW_W-1:0] cnt;
        logic                      out;
    } qpcc_str_t;

    qpcc_str_t s_reg;
    qpcc_str_t s_next;

    // A new trigger reloads the full width, even mid-pulse
    always_comb begin
        s_next = s_reg;
        if (trigger) begin
            s_next.cnt = width; // R4
            s_next.out = (width != qpcc_pkg::PW_RST); // R3
        end else if (s_reg.cnt > 16'h0001) begin
            s_next.cnt = s_reg.cnt - 16'h0001;
        end else begin
            s_next.cnt = qpcc_pkg::PW_RST;
            s_next.out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pulse = s_reg.out;

    // Restart loads the whole width from the newest trigger
    a_restart_width: assert property (@(posedge clk) disable iff (rst)
        trigger && width != 16'h0000 |=> pulse && s_reg.cnt == $past(width)) // R4
        else $error("stretcher did not reload width");

    a_pulse_ends: assert property (@(posedge clk) disable iff (rst)
        !trigger && s_reg.cnt <= 16'h0001 |=> !pulse) // R3
        else $error("stretched pulse overran");

endmodule : qpcc_stretch
`default_nettype wire

// file: qpcc_encoder.sv
// Quadrature encoder model standing in for the disk and its two sensors.
// Assumes clk is the block's system clock; the bench calls step to move.
`timescale 1ns/100ps
`default_nettype none
module qpcc_encoder (
    input  wire logic clk,
    output var  logic qep_a,
    output var  logic qep_b
);
    logic [1:0] phase_reg;

    // Both lines idle low until the first step
    initial begin
        phase_reg = 2'h0;
        qep_a     = 1'b0;
        qep_b     = 1'b0;
    end

    // Gray sequence: one line changes per step, so one count each
    task automatic step(input logic fwd);
        @(posedge clk);
        phase_reg = fwd ? phase_reg + 2'h1 : phase_reg - 2'h1;
        qep_a <= phase_reg[1] ^ phase_reg[0];
        qep_b <= phase_reg[1];
    endtask : step
endmodule : qpcc_encoder
`default_nettype wire

// file: qpcc_top_tb_top.sv
// Self-checking bench for the position compare and capture block.
// Assumes qpcc_pkg and qpcc_top compiled first; encoder model drives A/B.
`timescale 1ns/100ps
`default_nettype none
module qpcc_top_tb_top;
    logic                        clk, rst, qep_a, qep_b, compare_write, compare_load_on_match;
    logic                        unit_timer_enable, count_pulse, direction, compare_sync_output;
    logic                        capture_suspended, interrupt;
    logic [qpcc_pkg::POS_W-1:0]  maximum_position, position_compare_value, position_count;
    logic [qpcc_pkg::POS_W-1:0]  compare_active, latched_position;
    logic [qpcc_pkg::PW_W-1:0]   sync_pulse_width;
    logic [qpcc_pkg::UTMR_W-1:0] unit_period_value, unit_timer_count;
    logic [qpcc_pkg::CCPS_W-1:0] capture_prescale;
    logic [qpcc_pkg::UNIT_POSITION_PRESCALE_W-1:0] unit_position_prescale;
    logic [qpcc_pkg::SPD_W-1:0]  speed_threshold;
    logic [qpcc_pkg::STS_N-1:0]  status_clear, decoder_status_reg;
    logic [qpcc_pkg::INT_N-1:0]  interrupt_enable_reg, interrupt_flag_reg;
    logic [qpcc_pkg::CTMR_W-1:0] capture_timer, capture_period_reg;
    int                          miscompares, samples_checked, cycles, hi_cnt;

    qpcc_encoder enc_u (.clk, .qep_a, .qep_b);

    qpcc_top dut_u (.clk, .rst, .qep_a, .qep_b, .maximum_position, .compare_write,
        .position_compare_value, .compare_load_on_match, .sync_pulse_width,
        .unit_timer_enable, .unit_period_value, .capture_prescale, .unit_position_prescale,
        .speed_threshold, .status_clear, .interrupt_enable_reg, .count_pulse, .direction,
        .position_count, .compare_active, .compare_sync_output, .unit_timer_count,
        .latched_position, .capture_timer, .capture_period_reg, .capture_suspended,
        .decoder_status_reg, .interrupt_flag_reg, .interrupt);

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard and sync pulse length counter
    always @(posedge clk) begin
        cycles++;
        if (compare_sync_output === 1'b1) hi_cnt++;
        if (cycles == 90000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Lets n edges land, then samples settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic write_shadow(input logic [31:0] v);
        @(posedge clk);
        compare_write          <= 1'b1;
        position_compare_value <= v;
        @(posedge clk);
        compare_write          <= 1'b0;
    endtask : write_shadow

    // Counting, wrap both ways, zero-load of compare, enables and masking
    task automatic wrap_compare();
        write_shadow(32'h0000_0002);
        repeat (3) begin
            enc_u.step(1'b1);
            tick(1);
            check("count_pulse", count_pulse, 1);
            check("active held", compare_active, 0);
        end
        check("position", position_count, 3);
        enc_u.step(1'b1);
        tick(1);
        check("wrap up", position_count, 0);
        check("ovf flag", interrupt_flag_reg[qpcc_pkg::INT_OVF], 1);
        check("cmp flag", interrupt_flag_reg[qpcc_pkg::INT_CMP], 1);
        check("interrupt", interrupt, 1);
        check("zero load", compare_active, 2);
        tick(1);
        check("flags cleared", interrupt_flag_reg, 0);
        check("int cleared", interrupt, 0);
        repeat (3) begin
            check("sync high", compare_sync_output, 1);
            tick(1);
        end
        check("sync low", compare_sync_output, 0);
        enc_u.step(1'b0);
        tick(1);
        check("wrap down", position_count, 3);
        check("unf flag", interrupt_flag_reg[qpcc_pkg::INT_UNF], 1);
        check("dir flag", interrupt_flag_reg[qpcc_pkg::INT_DIR], 1);
        check("direction", direction, 0);
        check("interrupt", interrupt, 1);
        @(posedge clk);
        interrupt_enable_reg <= 5'h17;
        enc_u.step(1'b0);
        tick(1);
        check("cmp flag", interrupt_flag_reg[qpcc_pkg::INT_CMP], 1);
        check("masked", interrupt, 0);
    endtask : wrap_compare

    // Matches two cycles apart stretch the pulse, then load on match
    task automatic restart_and_match_load();
        @(posedge clk);
        sync_pulse_width      <= 16'h0004;
        compare_load_on_match <= 1'b1;
        tick(4);
        hi_cnt = 0;
        enc_u.step(1'b0);
        enc_u.step(1'b1);
        enc_u.step(1'b0);
        enc_u.step(1'b1);
        tick(20);
        check("stretched", hi_cnt, 6);
        write_shadow(32'h0000_0003);
        enc_u.step(1'b0);
        tick(3);
        check("no match load", compare_active, 2);
        enc_u.step(1'b1);
        tick(1);
        check("match load", compare_active, 3);
    endtask : restart_and_match_load

    // Period 2 gives a timeout every third clock
    task automatic unit_timer();
        @(posedge clk);
        unit_period_value <= 32'h0000_0002;
        unit_timer_enable <= 1'b1;
        for (int i = 0; i < 10 && interrupt_flag_reg[qpcc_pkg::INT_UTO] !== 1'b1; i++) tick(1);
        check("timeout int", interrupt, 1);
        check("latched", latched_position, 32'h0000_0002);
        check("timer cleared", unit_timer_count, 0);
        tick(1);
        check("timer 1", unit_timer_count, 1);
        tick(1);
        check("timer 2", unit_timer_count, 2);
        tick(1);
        check("timeout again", interrupt_flag_reg[qpcc_pkg::INT_UTO], 1);
        check("not suspended", capture_suspended, 0);
        @(posedge clk);
        unit_timer_enable <= 1'b0;
        tick(3);
        repeat (6) begin
            tick(1);
            check("timer idle", unit_timer_count, 0);
            check("no timeout", interrupt_flag_reg[qpcc_pkg::INT_UTO], 0);
        end
    endtask : unit_timer

    task automatic clear_status();
        @(posedge clk);
        status_clear <= 3'h7;
        @(posedge clk);
        status_clear <= 3'h0;
        tick(1);
    endtask : clear_status

    // Capture events, direction error, prescaled events and overflow
    task automatic capture();
        clear_status();
        enc_u.step(1'b1);
        tick(3);
        check("new capture", decoder_status_reg, 3'h1);
        check("timer cleared", capture_timer < 16'h0004, 1);
        enc_u.step(1'b0);
        tick(3);
        check("dir error", decoder_status_reg[qpcc_pkg::STS_DIRECTION_CHANGE_ERROR], 1);
        @(posedge clk);
        unit_position_prescale <= 4'h1;
        clear_status();
        enc_u.step(1'b0);
        tick(3);
        check("half event", decoder_status_reg[qpcc_pkg::STS_CAPNEW], 0);
        enc_u.step(1'b0);
        tick(3);
        check("full event", decoder_status_reg[qpcc_pkg::STS_CAPNEW], 1);
        clear_status();
        tick(65540);
        check("overflow", decoder_status_reg[qpcc_pkg::STS_CAPTURE_OVERFLOW_ERROR], 1);
        check("saturated", capture_timer, 16'hffff);
        clear_status();
        check("set wins", decoder_status_reg, 3'h4);
        enc_u.step(1'b0);
        enc_u.step(1'b0);
        clear_status();
        check("period", capture_period_reg, 16'hffff);
        check("cleared", decoder_status_reg, 0);
    endtask : capture

    // Prescaled capture clock, then suspension above the speed threshold
    task automatic slow_capture();
        @(posedge clk);
        capture_prescale       <= 3'h2;
        unit_position_prescale <= 4'h0;
        enc_u.step(1'b0);
        tick(9);
        check("prescaled", capture_timer, 16'h0002);
        @(posedge clk);
        speed_threshold   <= 16'h0000;
        unit_period_value <= 32'h0000_0007;
        unit_timer_enable <= 1'b1;
        enc_u.step(1'b0);
        tick(12);
        check("suspended", capture_suspended, 1);
        check("timer held", capture_timer, 16'h0000);
        tick(4);
        check("resumed", capture_suspended, 0);
    endtask : slow_capture

    // Main sequence: quiet inputs, 16-cycle reset, then each scenario
    initial begin
        rst = 1'b1;
        compare_write = 1'b0;
        position_compare_value = 32'h0;
        compare_load_on_match = 1'b0;
        maximum_position = 32'h0000_0003;
        sync_pulse_width = 16'h0003;
        unit_timer_enable = 1'b0;
        unit_period_value = 32'h0;
        capture_prescale = 3'h0;
        unit_position_prescale = 4'h0;
        speed_threshold = 16'hffff;
        status_clear = 3'h0;
        interrupt_enable_reg = 5'h1f;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        hi_cnt = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        check("reset position", position_count, 0);
        check("reset flags", interrupt_flag_reg, 0);
        wrap_compare();
        restart_and_match_load();
        unit_timer();
        capture();
        slow_capture();
        end_sim();
    end
endmodule : qpcc_top_tb_top
`default_nettype wire
